/* common/event_pkg.sv */
// Constants shared by the event block packer and its helpers.
package event_pkg;
  // ----------------------------------------------------------------
  // Block identification codes
  // ----------------------------------------------------------------
  localparam logic [15:0] EVT_BLOCK_ID = 16'h26af;
  localparam logic [15:0] ERR_REQ_ID = 16'h26de;

  // ----------------------------------------------------------------
  // Block layout
  // ----------------------------------------------------------------
  localparam logic [7:0] BLK_LEN_60 = 8'h3c;
  localparam logic [7:0] BLK_LEN_120 = 8'h78;
  localparam logic [7:0] BLK_LEN_240 = 8'hf0;
  localparam logic [1:0] SIZE_SEL_60 = 2'h0;
  localparam logic [1:0] SIZE_SEL_120 = 2'h1;
  localparam logic [1:0] SIZE_SEL_240 = 2'h2;
  localparam logic [7:0] WORD_ID = 8'h00;
  localparam logic [7:0] WORD_WRITE_ID = 8'h01;
  localparam logic [7:0] WORD_COUNT = 8'h02;
  localparam logic [7:0] WORD_START = 8'h03;
  localparam logic [7:0] REC_FIRST_WORD = 8'h03;
  localparam logic [7:0] REC_WORDS = 8'h0a;
  localparam logic [2:0] REC_SLOTS = 3'h5;
  localparam logic [7:0] ERR_FIRST_WORD = 8'h04;
  localparam logic [7:0] ERR_SLOTS = 8'h32;

  // ----------------------------------------------------------------
  // Record fields and limits
  // ----------------------------------------------------------------
  localparam int REC_W = 160;
  localparam logic [5:0] COT_SPONTANEOUS = 6'h01;
  localparam logic [7:0] ASDU_TYPE_1 = 8'h01;
  localparam logic [7:0] ASDU_TYPE_2 = 8'h02;
  localparam logic [7:0] ASDU_TYPE_4 = 8'h04;
  localparam logic [15:0] MSEC_MAX = 16'hea5f;
  localparam int BIT_TIME_INVALID = 0;
  localparam int BIT_DST = 1;
  localparam int EVT_BUF_DEPTH = 256;
  localparam logic [8:0] EVT_OVF_LIMIT = 9'h0c8;
  localparam int ERR_TAB_DEPTH = 1000;
  localparam logic [10:0] MAX_CMD_LIMIT = 11'h3e8;
  localparam logic [7:0] ERR_REQ_MAX = 8'hc8;
endpackage : event_pkg

/* common/packer_if.sv */
// Interfaces joining the packer to its event buffer and error table.
`timescale 1ns/1ns
interface evt_buf_if;
  logic push;
  logic [event_pkg::REC_W-1:0] pushRec;
  logic [2:0] rdSel;
  logic [event_pkg::REC_W-1:0] rdRec;
  logic pop;
  logic [2:0] popCnt;
  logic [8:0] count;
  logic overflow;
  logic ovfClear;
  modport owner (output push, pushRec, rdSel, pop, popCnt, ovfClear, input rdRec, count, overflow);
  modport store (input push, pushRec, rdSel, pop, popCnt, ovfClear, output rdRec, count, overflow);
endinterface : evt_buf_if

interface err_tab_if;
  logic [9:0] rdAddr;
  logic [15:0] rdData;
  modport owner (output rdAddr, input rdData);
  modport store (input rdAddr, output rdData);
endinterface : err_tab_if

/* hw/error_table.sv */
// Table of the last error code recorded for each configured command.
`timescale 1ns/1ns
module error_table #(
  parameter int DEPTH = event_pkg::ERR_TAB_DEPTH
) (
  input wire logic clk_sys,
  input wire logic wrEn,
  input wire logic [9:0] wrIdx,
  input wire logic [15:0] wrData,
  err_tab_if.store bus
);
  logic [15:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wrEn && (32'(wrIdx) < DEPTH)) begin
      mem[wrIdx] <= wrData;
    end
  end

  // Out-of-range reads return zero rather than an undefined word.
  assign bus.rdData = (32'(bus.rdAddr) < DEPTH) ? mem[bus.rdAddr] : 16'h0000;
endmodule : error_table

/* hw/event_block_packer.sv */
// Event block packer: builds event and error-table blocks for the host processor.
// Contract
// - Event block word 0 carries the event block identification code.
// - Word 2 holds the number of events carried, within the legal range.
// - Each event is a 10-word record, records packed from word 3 onward.
// - Only spontaneous-cause messages are forwarded as events.
// - Record word 0: session index high byte, sector index low byte.
// - Record word 1: data unit type code.
// - Record word 2: function code high byte, point index low byte.
// - Record word 3: fault number, meaningful only for types 2 and 4.
// - Record word 4: seconds and milliseconds as one count 0 to 59999.
// - Record word 5: hour high byte, minute low byte.
// - Record word 6: bit 0 time invalid, bit 1 daylight saving.
// - Record word 7: relative time, meaningful only for types 2 and 4.
// - Record words 8-9: point value, 2-bit state for types 1 and 2.
// - Event blocks are built only while event pass-through is enabled.
// - Spontaneous events received while pass-through is on are appended to the internal event buffer until it is full.
// - Pending events are sent ahead of ordinary data blocks.
// - Events carried in a sent block are removed from the buffer.
// - More than 200 buffered events sets the overflow flag.
// - No acknowledgement follows an event block; the device never waits.
// - Error answer places one error word per command in words 4-53.
// - Blocks are 60, 120 or 240 words as configured.
`timescale 1ns/1ns
module event_block_packer #(
  parameter int EVT_DEPTH = event_pkg::EVT_BUF_DEPTH,
  parameter int ERR_DEPTH = event_pkg::ERR_TAB_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic passThroughEn,
  input wire logic [1:0] blkSizeSel,
  input wire logic [10:0] max_command_count,
  input wire logic [15:0] readBlockId,
  input wire logic [15:0] writeBlockId,
  input wire logic evtValid,
  input wire logic [5:0] evtCot,
  input wire logic [7:0] evtSession,
  input wire logic [7:0] evtSector,
  input wire logic [7:0] evtAsduType,
  input wire logic [7:0] evtFunc,
  input wire logic [7:0] evtPoint,
  input wire logic [15:0] evtFault,
  input wire logic [15:0] evtMsec,
  input wire logic [7:0] evtHour,
  input wire logic [7:0] evtMinute,
  input wire logic evtTimeInvalid,
  input wire logic evtDst,
  input wire logic [15:0] evtRelTime,
  input wire logic [31:0] evtValue,
  input wire logic ovfClear,
  input wire logic reqValid,
  input wire logic [7:0] reqIndex,
  input wire logic [15:0] reqWord,
  input wire logic reqLast,
  input wire logic cmdErrWrEn,
  input wire logic [9:0] cmdErrIdx,
  input wire logic [15:0] cmdErrData,
  input wire logic dataBlkReq,
  input wire logic blkReady,
  output logic blkValid,
  output logic [15:0] blkWord,
  output logic [7:0] blkIndex,
  output logic blkLast,
  output logic dataBlkGrant,
  output logic eventOverflow,
  output logic eventPending
);
  typedef enum logic [1:0] {ST_IDLE, ST_EVT, ST_ERR} send_e;

  evt_buf_if evtBus ();
  err_tab_if errBus ();

  event_buffer #(.DEPTH(EVT_DEPTH)) uEvtBuf (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .bus(evtBus.store)
  );

  error_table #(.DEPTH(ERR_DEPTH)) uErrTab (
    .clk_sys(clk_sys),
    .wrEn(cmdErrWrEn),
    .wrIdx(cmdErrIdx),
    .wrData(cmdErrData),
    .bus(errBus.store)
  );

  // ----------------------------------------------------------------
  // Event record assembly
  // ----------------------------------------------------------------
  logic [event_pkg::REC_W-1:0] newRec;
  logic typeFault;
  logic typeTwoBit;

  always_comb begin
    typeFault = (evtAsduType == event_pkg::ASDU_TYPE_2) || (evtAsduType == event_pkg::ASDU_TYPE_4);
    typeTwoBit = (evtAsduType == event_pkg::ASDU_TYPE_1) || (evtAsduType == event_pkg::ASDU_TYPE_2);
    newRec = '0;
    newRec[0 +: 16] = {evtSession, evtSector};
    newRec[16 +: 16] = {8'h00, evtAsduType};
    newRec[32 +: 16] = {evtFunc, evtPoint};
    newRec[48 +: 16] = typeFault ? evtFault : 16'h0000;
    newRec[64 +: 16] = (evtMsec > event_pkg::MSEC_MAX) ? event_pkg::MSEC_MAX : evtMsec;
    newRec[80 +: 16] = {evtHour, evtMinute};
    newRec[96 + event_pkg::BIT_TIME_INVALID] = evtTimeInvalid;
    newRec[96 + event_pkg::BIT_DST] = evtDst;
    newRec[112 +: 16] = typeFault ? evtRelTime : 16'h0000;
    newRec[128 +: 32] = typeTwoBit ? {30'h0, evtValue[1:0]} : evtValue;
  end

  // Events arriving while pass-through is off are not kept, so none leak out once it turns on.
  assign evtBus.push = evtValid && passThroughEn && (evtCot == event_pkg::COT_SPONTANEOUS);
  assign evtBus.pushRec = newRec;
  assign evtBus.ovfClear = ovfClear;

  // ----------------------------------------------------------------
  // Error request capture
  // ----------------------------------------------------------------
  logic [15:0] reqId_q;
  logic [15:0] reqCnt_q;
  logic [15:0] reqStart_q;
  logic errPending_q;
  logic [7:0] errCnt_q;
  logic [9:0] errStart_q;
  logic [10:0] maxCmd;
  logic [15:0] curId;
  logic [15:0] curCnt;
  logic [15:0] curStart;
  logic reqOk;
  logic [10:0] avail;
  logic [7:0] rptCnt;

  always_comb begin
    maxCmd = (max_command_count > event_pkg::MAX_CMD_LIMIT) ? event_pkg::MAX_CMD_LIMIT : max_command_count;
    curId = (reqIndex == event_pkg::WORD_ID) ? reqWord : reqId_q;
    curCnt = (reqIndex == event_pkg::WORD_WRITE_ID) ? reqWord : reqCnt_q;
    curStart = (reqIndex == event_pkg::WORD_COUNT) ? reqWord : reqStart_q;
    reqOk = (curId == event_pkg::ERR_REQ_ID) && (curCnt != 16'h0000)
      && (curCnt <= {8'h00, event_pkg::ERR_REQ_MAX})
      && (curStart < {5'h00, maxCmd});
    avail = maxCmd - curStart[10:0];
    rptCnt = curCnt[7:0];
    if (rptCnt > event_pkg::ERR_SLOTS) begin
      rptCnt = event_pkg::ERR_SLOTS;
    end
    if ({3'h0, rptCnt} > avail) begin
      rptCnt = avail[7:0];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      reqId_q <= '0;
      reqCnt_q <= '0;
      reqStart_q <= '0;
    end else if (reqValid) begin
      reqId_q <= reqLast ? 16'h0000 : curId;
      reqCnt_q <= curCnt;
      reqStart_q <= curStart;
    end
  end

  // ----------------------------------------------------------------
  // Block sender
  // ----------------------------------------------------------------
  send_e state_q;
  logic [2:0] evtN_q;
  logic [7:0] lastIdx_q;
  logic [7:0] lenLast;
  logic [7:0] nxtIdx;
  logic [7:0] recOff;
  logic [7:0] slot;
  logic [7:0] pos;
  logic [7:0] errOff;
  logic [15:0] nxtWord;
  logic [2:0] startN;
  logic wordTaken;
  logic endBlk;

  always_comb begin
    if (blkSizeSel == event_pkg::SIZE_SEL_240) begin
      lenLast = event_pkg::BLK_LEN_240 - 8'h01;
    end else if (blkSizeSel == event_pkg::SIZE_SEL_120) begin
      lenLast = event_pkg::BLK_LEN_120 - 8'h01;
    end else begin
      lenLast = event_pkg::BLK_LEN_60 - 8'h01;
    end
    startN = (evtBus.count > {6'h00, event_pkg::REC_SLOTS}) ? event_pkg::REC_SLOTS : evtBus.count[2:0];
  end

  assign wordTaken = blkValid && blkReady;
  assign endBlk = wordTaken && blkLast;
  assign nxtIdx = (state_q == ST_IDLE) ? 8'h00 : blkIndex + 8'h01;

  always_comb begin
    recOff = nxtIdx - event_pkg::REC_FIRST_WORD;
    slot = recOff / event_pkg::REC_WORDS;
    pos = recOff % event_pkg::REC_WORDS;
    errOff = nxtIdx - event_pkg::ERR_FIRST_WORD;
    evtBus.rdSel = slot[2:0];
    errBus.rdAddr = errStart_q + {2'h0, errOff};
    nxtWord = 16'h0000;
    if (state_q == ST_ERR) begin
      if (nxtIdx == event_pkg::WORD_ID) begin
        nxtWord = readBlockId;
      end else if (nxtIdx == event_pkg::WORD_WRITE_ID) begin
        nxtWord = event_pkg::ERR_REQ_ID;
      end else if (nxtIdx == event_pkg::WORD_COUNT) begin
        nxtWord = {8'h00, errCnt_q};
      end else if (nxtIdx == event_pkg::WORD_START) begin
        nxtWord = {6'h00, errStart_q};
      end else if (nxtIdx >= event_pkg::ERR_FIRST_WORD && errOff < errCnt_q) begin
        nxtWord = errBus.rdData;
      end
    end else begin
      if (nxtIdx == event_pkg::WORD_ID) begin
        nxtWord = event_pkg::EVT_BLOCK_ID;
      end else if (nxtIdx == event_pkg::WORD_WRITE_ID) begin
        nxtWord = writeBlockId;
      end else if (nxtIdx == event_pkg::WORD_COUNT) begin
        nxtWord = {13'h0000, (state_q == ST_IDLE) ? startN : evtN_q};
      end else if (nxtIdx >= event_pkg::REC_FIRST_WORD && slot < {5'h00, evtN_q}) begin
        nxtWord = evtBus.rdRec[pos * 16 +: 16];
      end
    end
  end

  // Removal happens as the last word is taken; no answer from the processor is awaited.
  assign evtBus.pop = (state_q == ST_EVT) && endBlk;
  assign evtBus.popCnt = evtN_q;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      errPending_q <= 1'b0;
      errCnt_q <= '0;
      errStart_q <= '0;
    end else if (reqValid && reqLast && reqOk) begin
      errPending_q <= 1'b1;
      errCnt_q <= rptCnt;
      errStart_q <= curStart[9:0];
    end else if (state_q == ST_ERR && endBlk) begin
      errPending_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state_q <= ST_IDLE;
      evtN_q <= '0;
      lastIdx_q <= '0;
      blkValid <= 1'b0;
      blkWord <= '0;
      blkIndex <= '0;
      blkLast <= 1'b0;
      dataBlkGrant <= 1'b0;
    end else begin
      dataBlkGrant <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          lastIdx_q <= lenLast;
          blkIndex <= 8'h00;
          blkWord <= nxtWord;
          blkLast <= 1'b0;
          if (passThroughEn && evtBus.count != 9'h000) begin
            state_q <= ST_EVT;
            evtN_q <= startN;
            blkValid <= 1'b1;
          end else if (errPending_q) begin
            state_q <= ST_ERR;
            blkValid <= 1'b1;
          end else begin
            dataBlkGrant <= dataBlkReq;
          end
          if (errPending_q && !(passThroughEn && evtBus.count != 9'h000)) begin
            blkWord <= readBlockId;
          end
        end
        default: begin
          if (endBlk) begin
            state_q <= ST_IDLE;
            blkValid <= 1'b0;
            blkLast <= 1'b0;
          end else if (wordTaken) begin
            blkIndex <= nxtIdx;
            blkWord <= nxtWord;
            blkLast <= (nxtIdx == lastIdx_q);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      eventOverflow <= 1'b0;
      eventPending <= 1'b0;
    end else begin
      eventOverflow <= evtBus.overflow;
      eventPending <= (evtBus.count != 9'h000);
    end
  end
endmodule : event_block_packer

/* hw/event_buffer.sv */
// Circular store of packed event records with overflow tracking.
`timescale 1ns/1ns
module event_buffer #(
  parameter int DEPTH = event_pkg::EVT_BUF_DEPTH
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  evt_buf_if.store bus
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [8:0] DEPTH_CNT = 9'(DEPTH);

  logic [event_pkg::REC_W-1:0] mem [DEPTH];
  logic [AW-1:0] head_q;
  logic [AW-1:0] tail_q;
  logic [8:0] count_q;
  logic overflow_q;
  logic pushOk;

  // A full store drops the newest event; the overflow flag has long been raised by then.
  assign pushOk = bus.push && (count_q < DEPTH_CNT);
  assign bus.rdRec = mem[head_q + AW'(bus.rdSel)];
  assign bus.count = count_q;
  assign bus.overflow = overflow_q;

  always_ff @(posedge clk_sys) begin
    if (pushOk) begin
      mem[tail_q] <= bus.pushRec;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      head_q <= '0;
      tail_q <= '0;
      count_q <= '0;
    end else begin
      if (pushOk) begin
        tail_q <= tail_q + 1'b1;
      end
      if (bus.pop) begin
        head_q <= head_q + AW'(bus.popCnt);
      end
      count_q <= count_q + {8'h00, pushOk} - (bus.pop ? {6'h00, bus.popCnt} : 9'h000);
    end
  end

  // Setting wins over a clear in the same cycle.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      overflow_q <= 1'b0;
    end else if (count_q > event_pkg::EVT_OVF_LIMIT) begin
      overflow_q <= 1'b1;
    end else if (bus.ovfClear) begin
      overflow_q <= 1'b0;
    end
  end
endmodule : event_buffer

/* testbench/event_block_packer_checker.sv */
// Port-level assertions for the event block packer.
`timescale 1ns/1ns
module event_block_packer_checker #(
  parameter int EVT_DEPTH = 256
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic passThroughEn,
  input wire logic [15:0] readBlockId,
  input wire logic evtValid,
  input wire logic [5:0] evtCot,
  input wire logic dataBlkReq,
  input wire logic blkReady,
  input wire logic blkValid,
  input wire logic [15:0] blkWord,
  input wire logic [7:0] blkIndex,
  input wire logic blkLast,
  input wire logic dataBlkGrant,
  input wire logic eventOverflow,
  input wire logic eventPending
);
  // --------------------------------------------------------------
  // Buffer occupancy rebuilt from the ports
  // --------------------------------------------------------------
  logic [8:0] cnt_q;
  logic [7:0] nq_q;
  logic evtBlk_q;
  logic push;
  assign push = evtValid && passThroughEn && evtCot == event_pkg::COT_SPONTANEOUS && 32'(cnt_q) < EVT_DEPTH;

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      cnt_q <= 9'h000;
      nq_q <= 8'h00;
      evtBlk_q <= 1'b0;
    end else begin
      if (blkValid && blkIndex == 8'h00) evtBlk_q <= blkWord == event_pkg::EVT_BLOCK_ID;
      if (blkValid && blkIndex == 8'h02) nq_q <= blkWord[7:0];
      cnt_q <= cnt_q + 9'(push) - ((blkValid && blkReady && blkLast && evtBlk_q) ? 9'(nq_q) : 9'h000);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  block_id_a: assert property (blkValid && blkIndex == 8'h00 |->
    blkWord == event_pkg::EVT_BLOCK_ID || blkWord == readBlockId) else $error("block opens with unknown code");
  evt_count_a: assert property (blkValid && blkIndex == 8'h02 && evtBlk_q |->
    blkWord inside {[16'h0001:16'h0005]}) else $error("event count out of range");
  word_hold_a: assert property (blkValid && !blkReady |=>
    blkValid && $stable(blkWord) && $stable(blkIndex)) else $error("word changed before taken");
  index_step_a: assert property (blkValid && blkReady && !blkLast |=>
    blkValid && blkIndex == $past(blkIndex) + 8'h01) else $error("word index did not advance by one");
  last_len_a: assert property (blkValid && blkLast |->
    blkIndex inside {8'h3b, 8'h77, 8'hef}) else $error("block length not 60, 120 or 240");
  block_gap_a: assert property (blkValid && blkReady && blkLast |=> !blkValid)
    else $error("no idle cycle after last word");
  pend_track_a: assert property (1'b1 |-> eventPending == ($past(cnt_q) != 9'h000))
    else $error("pending flag disagrees with buffer fill");
  ovf_set_a: assert property (cnt_q > event_pkg::EVT_OVF_LIMIT |-> ##[1:2] eventOverflow)
    else $error("overflow not flagged above 200");
  ovf_cause_a: assert property ($rose(eventOverflow) |-> cnt_q > event_pkg::EVT_OVF_LIMIT ||
    $past(cnt_q) > event_pkg::EVT_OVF_LIMIT || $past(cnt_q, 2) > event_pkg::EVT_OVF_LIMIT)
    else $error("overflow raised without cause");
  grant_order_a: assert property (dataBlkGrant |-> !blkValid && $past(dataBlkReq) &&
    !(eventPending && $past(passThroughEn)))
    else $error("data grant while a block is out");

  cover property (blkValid && blkIndex == 8'h00 && blkWord == event_pkg::EVT_BLOCK_ID);
  cover property (blkValid && blkIndex == 8'h01 && blkWord == event_pkg::ERR_REQ_ID);
  cover property ($rose(eventOverflow));
  cover property (dataBlkGrant);
endmodule : event_block_packer_checker

bind event_block_packer event_block_packer_checker #(.EVT_DEPTH(EVT_DEPTH)) event_block_packer_checker_i (
  .clk_sys, .rst_b, .passThroughEn, .readBlockId, .evtValid, .evtCot, .dataBlkReq, .blkReady,
  .blkValid, .blkWord, .blkIndex, .blkLast, .dataBlkGrant, .eventOverflow, .eventPending
);

/* testbench/event_block_packer_tb_top.sv */
// Bench: drives events and requests, checks blocks against a queue model.
`timescale 1ns/1ns
module event_block_packer_tb_top;
  logic clk_sys = 1'b0;
  logic rst_b, passThroughEn, evtValid, evtTimeInvalid, evtDst, ovfClear, cmdErrWrEn, dataBlkReq, hold;
  logic reqValid, reqLast, blkReady, blkValid, blkLast, dataBlkGrant, eventOverflow, eventPending;
  logic [1:0] blkSizeSel;
  logic [10:0] max_command_count;
  logic [5:0] evtCot;
  logic [7:0] evtSession, evtSector, evtAsduType, evtFunc, evtPoint, evtHour, evtMinute, reqIndex, blkIndex;
  logic [9:0] cmdErrIdx;
  logic [15:0] readBlockId, writeBlockId, evtFault, evtMsec, evtRelTime, reqWord, cmdErrData, blkWord;
  logic [31:0] evtValue;
  logic [159:0] q[$];
  logic [15:0] errTab [1000];
  logic [15:0] want[$];
  logic [47:0] bad [4] = '{{16'h26df, 16'h0005, 16'h0000}, {event_pkg::ERR_REQ_ID, 16'h0000, 16'h0000},
    {event_pkg::ERR_REQ_ID, 16'h00c9, 16'h0000}, {event_pkg::ERR_REQ_ID, 16'h0005, 16'h03e8}};
  int lenTab [4] = '{60, 120, 240, 60};
  int cntTab [4] = '{60, 20, 200, 1};
  int stTab [4] = '{100, 990, 999, 0};
  int seed = 53447;
  int err_total = 0;
  int n_checks = 0;

  always #10 clk_sys = ~clk_sys;

  event_block_packer event_block_packer_i (
    .clk_sys, .rst_b, .passThroughEn, .blkSizeSel, .max_command_count, .readBlockId, .writeBlockId,
    .evtValid, .evtCot, .evtSession, .evtSector, .evtAsduType, .evtFunc, .evtPoint, .evtFault, .evtMsec,
    .evtHour, .evtMinute, .evtTimeInvalid, .evtDst, .evtRelTime, .evtValue, .ovfClear, .reqValid,
    .reqIndex, .reqWord, .reqLast, .cmdErrWrEn, .cmdErrIdx, .cmdErrData, .dataBlkReq, .blkReady,
    .blkValid, .blkWord, .blkIndex, .blkLast, .dataBlkGrant, .eventOverflow, .eventPending
  );

  host_model host_model_i (
    .clk_sys, .hold, .blkValid, .blkWord, .blkIndex, .blkLast, .blkReady, .reqValid, .reqIndex,
    .reqWord, .reqLast, .blkDone(), .blkLen(), .blkMem()
  );

  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] expv);
    n_checks++;
    if (got !== expv) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, expv, got);
    end
  endtask : chk

  task automatic results;
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  task automatic sendEvt(input logic [5:0] cot);
    logic [31:0] a, b, c, v;
    logic [1:0] f;
    logic [7:0] t;
    logic k;
    a = $random(seed);
    b = $random(seed);
    c = $random(seed);
    v = $random(seed);
    f = 2'($random(seed));
    t = 8'({$random(seed)} % 5);
    k = t == event_pkg::ASDU_TYPE_2 || t == event_pkg::ASDU_TYPE_4;
    @(posedge clk_sys);
    evtValid <= 1'b1;
    evtCot <= cot;
    evtAsduType <= t;
    {evtSession, evtSector, evtFunc, evtPoint} <= a;
    {evtFault, evtRelTime} <= b;
    {evtHour, evtMinute, evtMsec} <= c;
    {evtDst, evtTimeInvalid} <= f;
    evtValue <= v;
    if (passThroughEn && cot == event_pkg::COT_SPONTANEOUS && q.size() < 256) begin
      q.push_back({(t == event_pkg::ASDU_TYPE_1 || t == event_pkg::ASDU_TYPE_2) ? {30'h0, v[1:0]} : v,
        k ? b[15:0] : 16'h0000, {14'h0, f}, c[31:16],
        c[15:0] > event_pkg::MSEC_MAX ? event_pkg::MSEC_MAX : c[15:0], k ? b[31:16] : 16'h0000,
        a[15:0], {8'h00, t}, a[31:16]});
    end
  endtask : sendEvt

  task automatic sendMany(input int n);
    for (int i = 0; i < n; i++) begin
      sendEvt(({$random(seed)} % 8 == 0) ? 6'h03 : event_pkg::COT_SPONTANEOUS);
    end
    @(posedge clk_sys);
    evtValid <= 1'b0;
  endtask : sendMany

  task automatic getBlk;
    int w = 0;
    do begin
      @(negedge clk_sys);
      w++;
    end while (host_model_i.blkDone !== 1'b1 && w < 5000);
    chk("done", 16'(host_model_i.blkDone), 16'h0001);
  endtask : getBlk

  task automatic cmpWant(input string nm);
    chk("length", 16'(host_model_i.blkLen), 16'(want.size()));
    foreach (want[i]) chk(nm, host_model_i.blkMem[i], want[i]);
  endtask : cmpWant

  // --------------------------------------------------------------
  // Expected blocks
  // --------------------------------------------------------------
  // The count is fixed at block start, so it is read from the block; its records must be the oldest.
  task automatic expEvt;
    int n;
    getBlk();
    n = int'(host_model_i.blkMem[2]);
    chk("count", 16'(n >= 1 && n <= 5 && n <= q.size()), 16'h0001);
    want = {event_pkg::EVT_BLOCK_ID, writeBlockId, 16'(n)};
    for (int i = 3; i < lenTab[blkSizeSel]; i++) begin
      want.push_back(i < 3 + 10 * n ? q[(i - 3) / 10][16 * ((i - 3) % 10) +: 16] : 16'h0000);
    end
    cmpWant("event word");
    repeat (n) void'(q.pop_front());
  endtask : expEvt

  task automatic reqErr(input int cnt, input int st);
    int n;
    n = cnt < 50 ? cnt : 50;
    n = n < 1000 - st ? n : 1000 - st;
    host_model_i.sendReq(event_pkg::ERR_REQ_ID, 16'(cnt), 16'(st));
    getBlk();
    want = {readBlockId, event_pkg::ERR_REQ_ID, 16'(n), 16'(st)};
    for (int i = 4; i < lenTab[blkSizeSel]; i++) begin
      want.push_back(i < 4 + n ? errTab[st + i - 4] : 16'h0000);
    end
    cmpWant("error word");
  endtask : reqErr

  initial begin
    int w;
    {rst_b, passThroughEn, evtValid, ovfClear, cmdErrWrEn, dataBlkReq, blkSizeSel, evtCot, evtSession,
      evtSector, evtAsduType, evtFunc, evtPoint, evtFault, evtMsec, evtHour, evtMinute, evtTimeInvalid,
      evtDst, evtRelTime, evtValue, cmdErrIdx, cmdErrData} = '0;
    hold = 1'b1;
    max_command_count = 11'h7ff;
    writeBlockId = 16'($random(seed));
    readBlockId = 16'($random(seed)) & 16'h0fff;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(negedge clk_sys);
    chk("valid", 16'(blkValid), 16'h0000);
    chk("overflow", 16'(eventOverflow), 16'h0000);
    sendMany(3);
    repeat (5) @(negedge clk_sys);
    chk("pending", 16'(eventPending), 16'h0000);
    for (int i = 0; i < 1000; i++) begin
      @(posedge clk_sys);
      errTab[i] = 16'($random(seed));
      cmdErrWrEn <= 1'b1;
      cmdErrIdx <= 10'(i);
      cmdErrData <= errTab[i];
    end
    @(posedge clk_sys);
    cmdErrWrEn <= 1'b0;
    hold <= 1'b0;
    foreach (bad[i]) begin
      host_model_i.sendReq(bad[i][47:32], bad[i][31:16], bad[i][15:0]);
      repeat (20) @(negedge clk_sys) chk("idle", 16'(blkValid), 16'h0000);
    end
    @(posedge clk_sys);
    passThroughEn <= 1'b1;
    dataBlkReq <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      @(posedge clk_sys);
      blkSizeSel <= 2'(s);
      hold <= 1'b1;
      sendMany(9);
      hold <= 1'b0;
      while (q.size() > 0) expEvt();
      reqErr(cntTab[s], stTab[s]);
      w = 0;
      do begin
        @(negedge clk_sys);
        w++;
      end while (dataBlkGrant !== 1'b1 && w < 20);
      chk("grant", 16'(dataBlkGrant), 16'h0001);
    end
    @(posedge clk_sys);
    hold <= 1'b1;
    blkSizeSel <= 2'h0;
    sendMany(300);
    repeat (3) @(negedge clk_sys);
    chk("overflow", 16'(eventOverflow), 16'h0001);
    @(posedge clk_sys);
    ovfClear <= 1'b1;
    @(posedge clk_sys);
    ovfClear <= 1'b0;
    hold <= 1'b0;
    @(negedge clk_sys);
    chk("overflow", 16'(eventOverflow), 16'h0001);
    while (q.size() > 0) expEvt();
    chk("overflow", 16'(eventOverflow), 16'h0001);
    @(posedge clk_sys);
    ovfClear <= 1'b1;
    @(posedge clk_sys);
    ovfClear <= 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("overflow", 16'(eventOverflow), 16'h0000);
    results();
  end

  initial begin
    repeat (40000) @(posedge clk_sys);
    err_total++;
    results();
  end
endmodule : event_block_packer_tb_top

/* testbench/host_model.sv */
// Host processor model: takes blocks word by word and sends request blocks.
`timescale 1ns/1ns
module host_model (
  input wire logic clk_sys,
  input wire logic hold,
  input wire logic blkValid,
  input wire logic [15:0] blkWord,
  input wire logic [7:0] blkIndex,
  input wire logic blkLast,
  output logic blkReady,
  output logic reqValid,
  output logic [7:0] reqIndex,
  output logic [15:0] reqWord,
  output logic reqLast,
  output logic blkDone,
  output logic [7:0] blkLen,
  output logic [15:0] blkMem [240]
);
  int seed = 7;

  initial begin
    {blkReady, reqValid, reqIndex, reqWord, reqLast, blkDone, blkLen} = '0;
  end

  // --------------------------------------------------------------
  // Block intake
  // --------------------------------------------------------------
  // Random stalls make each word stand until taken; no reply is ever sent.
  always @(posedge clk_sys) begin
    blkReady <= !hold && ({$random(seed)} % 4 != 0);
    blkDone <= 1'b0;
    if (blkValid && blkReady) begin
      blkMem[blkIndex] <= blkWord;
      if (blkLast) begin
        blkDone <= 1'b1;
        blkLen <= blkIndex + 8'h01;
      end
    end
  end

  task automatic sendReq(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w2);
    for (int i = 0; i < 60; i++) begin
      @(posedge clk_sys);
      reqValid <= 1'b1;
      reqIndex <= 8'(i);
      reqWord <= i == 0 ? w0 : i == 1 ? w1 : i == 2 ? w2 : 16'(i);
      reqLast <= i == 59;
    end
    @(posedge clk_sys);
    reqValid <= 1'b0;
    reqLast <= 1'b0;
    reqWord <= ~reqWord;
  endtask : sendReq
endmodule : host_model
